//--- common/umc_map.svh
// Register offsets, field positions and reset values of the modem control block
`ifndef UMC_MAP_SVH
`define UMC_MAP_SVH

// Register byte offsets
`define UMC_OFS_MCTRL 8'h00
`define UMC_OFS_MSTAT 8'h04
`define UMC_OFS_IMASK 8'h08
`define UMC_OFS_ISTAT 8'h0c

// Modem control register fields
`define UMC_MC_DTR 0
`define UMC_MC_RTS 1
`define UMC_MC_OUTA 2
`define UMC_MC_OUTB 3
`define UMC_MC_LOOP 4
`define UMC_MC_ACTS 5
`define UMC_MC_WIDTH 6

// Modem status register fields
`define UMC_MS_DCTS 0
`define UMC_MS_DDSR 1
`define UMC_MS_RING_EDGE 2
`define UMC_MS_DDCD 3
`define UMC_MS_CTS 4
`define UMC_MS_DSR 5
`define UMC_MS_RI 6
`define UMC_MS_DCD 7

// Interrupt status and mask fields
`define UMC_IS_RXDATA 0
`define UMC_IS_THRE 1
`define UMC_IS_RXERR 2
`define UMC_IS_MODEM 3
`define UMC_IS_WIDTH 4

// Reset values
`define UMC_RST_MCTRL 6'h00
`define UMC_RST_IMASK 4'h0

`endif

//--- common/umc_pkg.sv
// Types shared by the modem control block
package umc_pkg;

  typedef enum logic {
    umc_ph_idle,
    umc_ph_access
  } umc_phase_type;

  typedef logic [3:0] umc_irq_vec_type;

  typedef logic [3:0] umc_modem_vec_type;

endpackage

//--- hw/umc_edge_det.sv
// Edge detector for a group of synchronous inputs; pulses are combinational against the registered last level
`timescale 1ns/100ps
`default_nettype none

module umc_edge_det #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sampled level
  input wire logic [WIDTH-1:0] level_in,
  // Edge pulses, one cycle each
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] nxt_prev;

  always_comb begin
    nxt_prev = level_in;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_edge
      assign rise[gi] = level_in[gi] & ~prev_ff[gi];
      assign fall[gi] = ~level_in[gi] & prev_ff[gi];
    end
  endgenerate

endmodule

`default_nettype wire

//--- hw/umc_irq.sv
// Sticky interrupt status with mask and a registered request line
`timescale 1ns/100ps
`default_nettype none

module umc_irq #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event pulses, write-one-to-clear and hardware clear
  input wire logic [N-1:0] set_vec,
  input wire logic [N-1:0] w1c_vec,
  input wire logic [N-1:0] hw_clr_vec,
  input wire logic [N-1:0] mask,
  // State
  output logic [N-1:0] status,
  output logic irq
);

  logic [N-1:0] status_ff;
  logic [N-1:0] nxt_status;
  logic irq_ff;
  logic nxt_irq;

  always_comb begin
    // A set in the clearing cycle wins
    nxt_status = (status_ff & ~(w1c_vec | hw_clr_vec)) | set_vec;
    nxt_irq = |(nxt_status & mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= nxt_irq;
    end
  end

  assign status = status_ff;
  assign irq = irq_ff;

endmodule

`default_nettype wire

//--- hw/umc_top.sv
// Modem control, modem status and interrupt pin logic behind an APB slave
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "umc_map.svh"

module umc_top
  import umc_pkg::*;
(
  // Clock and master reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Modem inputs, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  // Modem outputs, active low
  output logic dtr_n,
  output logic rts_n,
  output logic user_out_a_n,
  output logic user_out_b_n,
  // Receiver clock and its sample tick
  input wire logic rcv_clk16,
  output logic rcv_tick,
  // Interrupt sources from the serial datapath
  input wire logic fifo_mode,
  input wire logic rx_data_avail,
  input wire logic rx_timeout,
  input wire logic rx_error,
  input wire logic thr_empty,
  // CPU side pins
  output logic irq_out,
  output logic xcvr_drive_off
);

  // APB phase and answer
  umc_phase_type phase_ff;
  umc_phase_type nxt_phase;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic drive_off_ff;
  logic nxt_drive_off;
  // Control registers
  logic [`UMC_MC_WIDTH-1:0] modem_ctrl_reg_ff;
  logic [`UMC_MC_WIDTH-1:0] nxt_modem_ctrl_reg;
  logic [`UMC_IS_WIDTH-1:0] imask_ff;
  logic [`UMC_IS_WIDTH-1:0] nxt_imask;
  // Modem status change flags, order cts, dsr, ri, dcd
  umc_modem_vec_type delta_ff;
  umc_modem_vec_type nxt_delta;
  // Modem outputs and receiver tick
  logic dtr_n_ff;
  logic rts_n_ff;
  logic out_a_n_ff;
  logic out_b_n_ff;
  logic nxt_dtr_n;
  logic nxt_rts_n;
  logic nxt_out_a_n;
  logic nxt_out_b_n;
  logic rcv_tick_ff;
  logic nxt_rcv_tick;
  logic setup;
  logic access_done;
  logic wr_en;
  logic rd_en;
  logic loop_on;
  umc_modem_vec_type modem_lvl;
  umc_modem_vec_type modem_rise;
  umc_modem_vec_type modem_fall;
  umc_modem_vec_type modem_evt;
  logic [0:0] rclk_rise;
  logic msr_read;
  logic modem_irq_evt;
  umc_irq_vec_type irq_set;
  umc_irq_vec_type irq_w1c;
  umc_irq_vec_type irq_hw_clr;
  umc_irq_vec_type irq_status;
  logic irq_line;
  logic [7:0] msr_value;

  // Address decode used by both write enable and error answer
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `UMC_OFS_MCTRL) || (a == `UMC_OFS_MSTAT) ||
                  (a == `UMC_OFS_IMASK) || (a == `UMC_OFS_ISTAT);
  endfunction

  assign setup = psel && !penable;
  assign access_done = psel && penable && pready_ff;
  assign wr_en = access_done && pwrite && addr_mapped(paddr);
  assign rd_en = access_done && !pwrite;
  assign loop_on = modem_ctrl_reg_ff[`UMC_MC_LOOP];
  assign msr_read = rd_en && (paddr == `UMC_OFS_MSTAT);

  // Modem levels as true-high conditions; loopback feeds back the controls
  always_comb begin
    if (loop_on) begin
      modem_lvl[0] = modem_ctrl_reg_ff[`UMC_MC_RTS];
      modem_lvl[1] = modem_ctrl_reg_ff[`UMC_MC_DTR];
      modem_lvl[2] = modem_ctrl_reg_ff[`UMC_MC_OUTA];
      modem_lvl[3] = modem_ctrl_reg_ff[`UMC_MC_OUTB];
    end else begin
      modem_lvl[0] = ~cts_n;
      modem_lvl[1] = ~dsr_n;
      modem_lvl[2] = ~ri_n;
      modem_lvl[3] = ~dcd_n;
    end
  end

  umc_edge_det #(
    .WIDTH(4)
  ) u_modem_edges (
    .clk(clk),
    .rst(rst),
    .level_in(modem_lvl),
    .rise(modem_rise),
    .fall(modem_fall)
  );
  umc_edge_det #(
    .WIDTH(1)
  ) u_rclk_edge (
    .clk(clk),
    .rst(rst),
    .level_in(rcv_clk16),
    .rise(rclk_rise),
    .fall()
  );

  // Change events: any level change; ring flags only its pin rising (condition ends)
  always_comb begin
    modem_evt[0] = modem_rise[0] | modem_fall[0];
    modem_evt[1] = modem_rise[1] | modem_fall[1];
    modem_evt[2] = modem_fall[2];
    modem_evt[3] = modem_rise[3] | modem_fall[3];
  end

  // Status byte: levels high, change flags low
  always_comb begin
    msr_value = 8'h00;
    msr_value[`UMC_MS_DCTS] = delta_ff[0];
    msr_value[`UMC_MS_DDSR] = delta_ff[1];
    msr_value[`UMC_MS_RING_EDGE] = delta_ff[2];
    msr_value[`UMC_MS_DDCD] = delta_ff[3];
    msr_value[`UMC_MS_CTS] = modem_lvl[0];
    msr_value[`UMC_MS_DSR] = modem_lvl[1];
    msr_value[`UMC_MS_RI] = modem_lvl[2];
    msr_value[`UMC_MS_DCD] = modem_lvl[3];
    // A read clears only the flags it reported; newer changes survive it
    nxt_delta = (delta_ff & ~({4{msr_read}} & prdata_ff[3:0])) | modem_evt;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      delta_ff <= '0;
    end else begin
      delta_ff <= nxt_delta;
    end
  end

  // Interrupt sources; cts change is silent under automatic flow control
  always_comb begin
    modem_irq_evt = modem_evt[1] | modem_evt[2] | modem_evt[3] |
                    (modem_evt[0] & ~modem_ctrl_reg_ff[`UMC_MC_ACTS]);
    irq_set = '0;
    irq_set[`UMC_IS_RXDATA] = rx_data_avail | (rx_timeout & fifo_mode);
    irq_set[`UMC_IS_THRE] = thr_empty;
    irq_set[`UMC_IS_RXERR] = rx_error;
    irq_set[`UMC_IS_MODEM] = modem_irq_evt;
    irq_w1c = '0;
    if (wr_en && (paddr == `UMC_OFS_ISTAT)) begin
      irq_w1c = pwdata[`UMC_IS_WIDTH-1:0];
    end
    irq_hw_clr = '0;
    irq_hw_clr[`UMC_IS_MODEM] = msr_read && ((delta_ff & ~prdata_ff[3:0]) == 4'h0);
  end

  umc_irq #(
    .N(`UMC_IS_WIDTH)
  ) u_irq (
    .clk(clk),
    .rst(rst),
    .set_vec(irq_set),
    .w1c_vec(irq_w1c),
    .hw_clr_vec(irq_hw_clr),
    .mask(imask_ff),
    .status(irq_status),
    .irq(irq_line)
  );

  // Control register writes
  always_comb begin
    nxt_modem_ctrl_reg = modem_ctrl_reg_ff;
    nxt_imask = imask_ff;
    if (wr_en && (paddr == `UMC_OFS_MCTRL)) begin
      nxt_modem_ctrl_reg = pwdata[`UMC_MC_WIDTH-1:0];
    end
    if (wr_en && (paddr == `UMC_OFS_IMASK)) begin
      nxt_imask = pwdata[`UMC_IS_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      modem_ctrl_reg_ff <= `UMC_RST_MCTRL;
      imask_ff <= `UMC_RST_IMASK;
    end else begin
      modem_ctrl_reg_ff <= nxt_modem_ctrl_reg;
      imask_ff <= nxt_imask;
    end
  end

  // Modem outputs: low when set, high when cleared or in loopback
  always_comb begin
    nxt_dtr_n = ~(modem_ctrl_reg_ff[`UMC_MC_DTR] & ~loop_on);
    nxt_rts_n = ~(modem_ctrl_reg_ff[`UMC_MC_RTS] & ~loop_on);
    nxt_out_a_n = ~(modem_ctrl_reg_ff[`UMC_MC_OUTA] & ~loop_on);
    nxt_out_b_n = ~(modem_ctrl_reg_ff[`UMC_MC_OUTB] & ~loop_on);
    nxt_rcv_tick = rclk_rise[0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dtr_n_ff <= 1'b1;
      rts_n_ff <= 1'b1;
      out_a_n_ff <= 1'b1;
      out_b_n_ff <= 1'b1;
      rcv_tick_ff <= 1'b0;
    end else begin
      dtr_n_ff <= nxt_dtr_n;
      rts_n_ff <= nxt_rts_n;
      out_a_n_ff <= nxt_out_a_n;
      out_b_n_ff <= nxt_out_b_n;
      rcv_tick_ff <= nxt_rcv_tick;
    end
  end

  // APB answer: data and ready load at setup, so each access phase ends at its first edge
  always_comb begin
    nxt_phase = phase_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = prdata_ff;
    // Driver is enabled from the setup of a read until its completion
    nxt_drive_off = !(psel && !pwrite && !access_done);
    case (phase_ff)
      umc_ph_idle: begin
        if (setup) begin
          nxt_phase = umc_ph_access;
          nxt_pready = 1'b1;
          nxt_pslverr = !addr_mapped(paddr);
          nxt_prdata = 32'h0000_0000;
          if (!pwrite) begin
            case (paddr)
              `UMC_OFS_MCTRL: nxt_prdata[`UMC_MC_WIDTH-1:0] = modem_ctrl_reg_ff;
              `UMC_OFS_MSTAT: nxt_prdata[7:0] = msr_value;
              `UMC_OFS_IMASK: nxt_prdata[`UMC_IS_WIDTH-1:0] = imask_ff;
              `UMC_OFS_ISTAT: nxt_prdata[`UMC_IS_WIDTH-1:0] = irq_status;
              default: nxt_prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      umc_ph_access: begin
        if (access_done || !psel) begin
          nxt_phase = umc_ph_idle;
        end else begin
          nxt_pready = pready_ff;
          nxt_pslverr = pslverr_ff;
        end
      end
      default: begin
        nxt_phase = umc_ph_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_ff <= umc_ph_idle;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      drive_off_ff <= 1'b1;
    end else begin
      phase_ff <= nxt_phase;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
      drive_off_ff <= nxt_drive_off;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dtr_n = dtr_n_ff;
  assign rts_n = rts_n_ff;
  assign user_out_a_n = out_a_n_ff;
  assign user_out_b_n = out_b_n_ff;
  assign rcv_tick = rcv_tick_ff;
  assign irq_out = irq_line;
  assign xcvr_drive_off = drive_off_ff;

endmodule

`default_nettype wire

//--- tb/umc_modem_model.sv
// Modem side: pin levels on command and the receiver 16x clock
`timescale 1ns/100ps
`default_nettype none

module umc_modem_model #(
  parameter int HALF = 3
) (
  // Clock
  input wire logic clk,
  // Wanted levels {dcd, ri, dsr, cts}, active low
  input wire logic [3:0] want_n,
  // Modem pins
  output logic [3:0] pins_n,
  output logic rcv_clk16
);
  int cnt = 0;
  initial pins_n = 4'hf;
  initial rcv_clk16 = 1'b0;
  // Pins move one edge after the command, as a registered modem would
  always @(posedge clk) pins_n <= want_n;
  // Receive clock at sixteen times an assumed baud rate
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) rcv_clk16 <= ~rcv_clk16;
  end
endmodule
`default_nettype wire

//--- tb/umc_top_asserts.sv
// Concurrent checks on the ports of the modem control block
`timescale 1ns/100ps
`default_nettype none

module umc_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic dtr_n,
  input wire logic user_out_a_n,
  input wire logic user_out_b_n,
  input wire logic rcv_clk16,
  input wire logic rcv_tick,
  input wire logic irq_out,
  input wire logic xcvr_drive_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic wr_mc;
  logic [5:0] wd_ff;
  assign wr_mc = psel && penable && pready && pwrite && paddr == 8'h00;
  // Last control word written, held for the output checks
  always_ff @(posedge clk) begin
    if (wr_mc) begin
      wd_ff <= pwdata[5:0];
    end
  end
  property p_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
  property p_err;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c});
  endproperty
  a_err: assert property (p_err) else $error("error response wrong");
  property p_xcvr_drive_off_lo;
    psel && !penable && !pwrite |=> !xcvr_drive_off;
  endproperty
  a_xcvr_drive_off_lo: assert property (p_xcvr_drive_off_lo) else $error("driver off during read");
  property p_xcvr_drive_off_hi;
    (!psel || pwrite) [*2] |-> xcvr_drive_off;
  endproperty
  a_xcvr_drive_off_hi: assert property (p_xcvr_drive_off_hi) else $error("driver off low when idle");
  property p_dtr;
    wr_mc |=> ##1 dtr_n == !(wd_ff[0] && !wd_ff[4]);
  endproperty
  a_dtr: assert property (p_dtr) else $error("terminal ready level wrong");
  property p_outa;
    wr_mc |=> ##1 user_out_a_n == !(wd_ff[2] && !wd_ff[4]);
  endproperty
  a_outa: assert property (p_outa) else $error("user output a wrong");
  property p_outb;
    wr_mc |=> ##1 user_out_b_n == !(wd_ff[3] && !wd_ff[4]);
  endproperty
  a_outb: assert property (p_outb) else $error("user output b wrong");
  property p_rst;
    disable iff (1'b0)
    rst |=> dtr_n && user_out_a_n && user_out_b_n && !irq_out && xcvr_drive_off && !pready;
  endproperty
  a_rst: assert property (p_rst) else $error("reset levels wrong");
  property p_tick;
    $rose(rcv_clk16) |-> ##[1:2] rcv_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("no receive tick");
  property p_tick1;
    rcv_tick |=> !rcv_tick;
  endproperty
  a_tick1: assert property (p_tick1) else $error("receive tick too long");
endmodule

bind umc_top umc_chk umc_chk_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .dtr_n(dtr_n), .user_out_a_n(user_out_a_n), .user_out_b_n(user_out_b_n),
  .rcv_clk16(rcv_clk16), .rcv_tick(rcv_tick), .irq_out(irq_out),
  .xcvr_drive_off(xcvr_drive_off));
`default_nettype wire

//--- tb/umc_top_test.sv
// Self-checking bench for the modem control block
`timescale 1ns/100ps
`default_nettype none

module umc_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, dtr_n, rts_n, user_out_a_n, user_out_b_n;
  logic rcv_clk16, rcv_tick, irq_out, xcvr_drive_off;
  logic fifo_mode = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [3:0] want_n = 4'hf;
  logic [3:0] pins_n;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  logic [5:0] v;
  logic [31:0] m;
  int n_errors = 0;
  int checked = 0;
  int seed = 22121;
  int k, b;
  always #10 clk = ~clk;
  // Event inputs: ev[0] data, ev[1] holding empty, ev[2] error, ev[3] timeout
  umc_top umc_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cts_n(pins_n[0]), .dsr_n(pins_n[1]), .ri_n(pins_n[2]), .dcd_n(pins_n[3]),
    .dtr_n(dtr_n), .rts_n(rts_n), .user_out_a_n(user_out_a_n), .user_out_b_n(user_out_b_n),
    .rcv_clk16(rcv_clk16), .rcv_tick(rcv_tick), .fifo_mode(fifo_mode),
    .rx_data_avail(ev[0]), .rx_timeout(ev[3]), .rx_error(ev[2]), .thr_empty(ev[1]),
    .irq_out(irq_out), .xcvr_drive_off(xcvr_drive_off));
  umc_modem_model umc_modem_model_i (.clk(clk), .want_n(want_n), .pins_n(pins_n),
    .rcv_clk16(rcv_clk16));
  task automatic test_done();
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_rd(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: pin %b expected %b", $time, got, exp);
    end
  endtask
  // Reads carry the expected word in d; writes carry a zero compare mask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] mk, input logic err);
    int i;
    exp_q.push_back({err, mk, d});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(negedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      test_done();
    end
    chk_pin(xcvr_drive_off, w);
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, d, 32'hffffffff, 1'b0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic outs(input logic [5:0] c);
    chk_pin(dtr_n, !(c[0] && !c[4]));
    chk_pin(rts_n, !(c[1] && !c[4]));
    chk_pin(user_out_a_n, !(c[2] && !c[4]));
    chk_pin(user_out_b_n, !(c[3] && !c[4]));
  endtask
  always @(negedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk_rd({pslverr, prdata & e[63:32]}, {e[64], e[31:0] & e[63:32]});
    end
  end
  initial begin
    #1000000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wt(0);
    outs(6'h00);
    chk_pin(irq_out, 1'b0);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    for (k = 0; k < 8; k++) begin
      v = (k == 0) ? 6'h0f : (k == 1) ? 6'h1f : 6'($random(seed));
      wr(8'h00, {26'h0, v});
      wt(3);
      outs(v);
      rd(8'h00, {26'h0, v});
      if (k == 1) rd(8'h04, 32'hfb);
    end
    wr(8'h00, 32'h0f);
    wt(3);
    outs(6'h0f);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    wt(1);
    outs(6'h00);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h08, 32'h8);
    for (k = 0; k < 5; k++) begin
      b = k % 4;
      if (k == 4) wr(8'h00, 32'h20);
      @(posedge clk);
      want_n[b] <= 1'b0;
      wt(5);
      chk_pin(irq_out, b != 2 && k != 4);
      rd(8'h04, (32'h10 << b) | (32'(b != 2) << b));
      wt(2);
      chk_pin(irq_out, 1'b0);
      @(posedge clk);
      want_n[b] <= 1'b1;
      wt(5);
      chk_pin(irq_out, k != 4);
      rd(8'h04, 32'h1 << b);
      wt(2);
      chk_pin(irq_out, 1'b0);
    end
    wr(8'h00, 32'h0);
    for (k = 0; k < 5; k++) begin
      m = (k == 4) ? 32'h0 : 32'h1 << ((k == 3) ? 0 : k);
      wr(8'h08, 32'h0);
      fifo_mode <= (k == 3);
      @(posedge clk);
      ev <= 4'h1 << ((k == 4) ? 3 : k);
      @(posedge clk);
      ev <= 4'h0;
      wt(3);
      chk_pin(irq_out, 1'b0);
      rd(8'h0c, m);
      wr(8'h08, 32'hf);
      wt(3);
      chk_pin(irq_out, m != 0);
      wr(8'h0c, 32'hf);
      wt(3);
      chk_pin(irq_out, 1'b0);
      rd(8'h0c, 32'h0);
    end
    wr(8'h04, 32'hff);
    rd(8'h04, 32'h0);
    for (k = 0; k < 3; k++) begin
      paddr <= 8'h00;
      apb(1'b1, (k == 0) ? 8'h10 : (k == 1) ? 8'h40 : 8'hfc, 32'h3f, 32'h0, 1'b1);
      apb(1'b0, (k == 0) ? 8'h10 : (k == 1) ? 8'h40 : 8'hfc, 32'h0, 32'hffffffff, 1'b1);
    end
    rd(8'h00, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
